/* File: design/cvc_pkg.sv */
// Shared constants and types of the balancing converter controller
package cvc_pkg;

    // Timing
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SW_FREQ_KHZ = 250;
    localparam int unsigned PERIOD_CYC = CLK_HZ / (SW_FREQ_KHZ * 1000);
    localparam int unsigned DUTY_W = 10;
    localparam int unsigned DEAD_CYC = 8;
    localparam int unsigned RAMP_TIME_US = 300;
    localparam int unsigned RAMP_PERIODS = (RAMP_TIME_US * SW_FREQ_KHZ) / 1000;
    localparam int unsigned RAMP_STEP = (PERIOD_CYC + RAMP_PERIODS - 1) / RAMP_PERIODS;
    localparam int unsigned WDOG_TIME_US = 10_000;
    localparam int unsigned WDOG_CYC_DEFAULT = WDOG_TIME_US * (CLK_HZ / 1_000_000);

    // Register map, byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

    // Control fields
    localparam int unsigned CTRL_LIMIT_LSB = 0;
    localparam int unsigned CTRL_KICK_BIT = 16;
    localparam logic [DUTY_W-1:0] CTRL_LIMIT_RST = DUTY_W'(PERIOD_CYC);

    // Status fields
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_DONE_BIT = 4;
    localparam int unsigned STAT_DIR_BIT = 5;
    localparam int unsigned STAT_EN_BIT = 6;
    localparam int unsigned STAT_FAULT_LSB = 8;
    localparam int unsigned STAT_DUTY_LSB = 16;

    // Interrupt bits
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_FAULT_BIT = 1;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int unsigned FAULT_SRC_N = 7;
    localparam logic [2:0] FAULT_NONE = 3'h0;

    typedef enum logic [2:0] {
        CVC_IDLE,
        CVC_RUN,
        CVC_RAMP,
        CVC_DONE,
        CVC_FAULT
    } cvc_state_t;

    // Digitised comparator outputs of the sensing front end
    typedef struct packed {
        logic uvlo_main;
        logic uvlo_float;
        logic oc_primary;
        logic oc_secondary;
        logic cell_over;
        logic cell_under;
        logic over_temp;
    } cvc_fault_in_t;

    typedef struct packed {
        logic primary_switch_drive;
        logic secondary_switch_drive_a;
        logic secondary_switch_drive_b;
        logic clamp;
    } cvc_gate_t;

endpackage : cvc_pkg

/* File: design/cvc_pwm_gen.sv */
// Fixed-rate PWM timebase with dead-timed clamp window
`timescale 1ns/1ps
module cvc_pwm_gen #(
    parameter int unsigned PERIOD = cvc_pkg::PERIOD_CYC,
    parameter int unsigned DUTY_W = cvc_pkg::DUTY_W,
    parameter int unsigned DEAD = cvc_pkg::DEAD_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [DUTY_W-1:0] i_duty,
    output logic o_on,
    output logic o_clamp,
    output logic o_period_end
);

    initial
    begin
        if (PERIOD < 2 * DEAD + 2 || PERIOD > (1 << DUTY_W))
            $error("cvc_pwm_gen: period does not fit duty width");
    end

    logic [DUTY_W-1:0] count_reg;
    logic [DUTY_W-1:0] duty_reg;
    logic on_reg;
    logic clamp_reg;
    wire last_w = (count_reg == DUTY_W'(PERIOD - 1));
    // Clamp only while main switch is off, with margin on both sides
    wire clamp_w = (count_reg >= DUTY_W'(duty_reg + DUTY_W'(DEAD))) &&
                   (count_reg < DUTY_W'(PERIOD - DEAD)) && (duty_reg != '0);

    // Duty is taken once per period so a pulse is never cut mid-way
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count_reg <= '0;
            duty_reg <= '0;
            on_reg <= 1'b0;
            clamp_reg <= 1'b0;
        end
        else
        begin
            count_reg <= last_w ? '0 : DUTY_W'(count_reg + 1'b1);
            if (last_w)
                duty_reg <= i_duty;
            on_reg <= (count_reg < duty_reg);
            clamp_reg <= clamp_w;
        end
    end

    assign o_on = on_reg;
    assign o_clamp = clamp_reg;
    assign o_period_end = last_w;

endmodule : cvc_pwm_gen

/* File: design/cvc_ctrl.sv */
// Balancing converter control, enable handshake, fault latch and register slave
//
// How it works
// - Enable rise clears latches, starts current
// - Enable fall ramps down, then done
// - Ramp-down finishes within three hundred microseconds
// - Done stays latched until next enable rise
// - Direction high charges, low discharges
// - Heading echo is inverted direction
// - Fault latches code, shuts converter down
// - Detect supply, current, cell, thermal, watchdog
// - Fixed 250 kHz switching rate
// - Three PWM gates regulate around setpoint
// - Clamp timing output synced to cycle
// - One primary, two secondary gate drives
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module cvc_ctrl #(
    parameter logic [2:0] FC_UVLO_MAIN = 3'h1,
    parameter logic [2:0] FC_UVLO_FLOAT = 3'h2,
    parameter logic [2:0] FC_OC_PRIMARY = 3'h3,
    parameter logic [2:0] FC_OC_SECONDARY = 3'h4,
    parameter logic [2:0] FC_CELL = 3'h5,
    parameter logic [2:0] FC_OVER_TEMP = 3'h6,
    parameter logic [2:0] FC_WATCHDOG = 3'h7,
    parameter int unsigned WDOG_CYCLES = cvc_pkg::WDOG_CYC_DEFAULT
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Handshake with the switch matrix driver
    input wire logic i_enable,
    input wire logic i_direction,
    output logic o_heading_echo,
    output logic o_done,
    output logic [2:0] o_fault_code,
    // Strap-like inputs
    input wire logic i_latch_override_in,
    input wire logic i_test_select_in,
    input wire logic i_watchdog_bypass_in,
    // Sensing front end
    input wire logic [cvc_pkg::DUTY_W-1:0] i_current_setpoint_voltage,
    input wire cvc_pkg::cvc_fault_in_t i_fault_sense,
    // Gate outputs
    output cvc_pkg::cvc_gate_t o_gate,
    output logic o_irq,
    // AXI4-Lite slave
    input wire logic [cvc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [cvc_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);

    localparam int unsigned DW = cvc_pkg::DUTY_W;
    localparam int unsigned NF = cvc_pkg::FAULT_SRC_N;
    localparam logic [DW-1:0] STEP = DW'(cvc_pkg::RAMP_STEP);
    localparam logic [DW-1:0] MAX_DUTY = DW'(cvc_pkg::PERIOD_CYC - 2 * cvc_pkg::DEAD_CYC);

    initial
    begin
        if (FC_UVLO_MAIN == cvc_pkg::FAULT_NONE || FC_UVLO_FLOAT == cvc_pkg::FAULT_NONE ||
            FC_OC_PRIMARY == cvc_pkg::FAULT_NONE || FC_OC_SECONDARY == cvc_pkg::FAULT_NONE ||
            FC_CELL == cvc_pkg::FAULT_NONE || FC_OVER_TEMP == cvc_pkg::FAULT_NONE ||
            FC_WATCHDOG == cvc_pkg::FAULT_NONE)
            $error("cvc_ctrl: fault code zero is reserved for no fault");
        if (WDOG_CYCLES < 2)
            $error("cvc_ctrl: watchdog too short");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable edges and fault sources
    cvc_pkg::cvc_state_t state_reg;
    cvc_pkg::cvc_state_t state_next;
    logic enable_prev_reg;
    logic [DW-1:0] duty_reg;
    logic [DW-1:0] duty_next;
    logic done_reg;
    logic [2:0] fault_reg;
    logic [31:0] wdog_reg;
    logic [DW-1:0] limit_reg;
    logic [cvc_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [cvc_pkg::IRQ_W-1:0] irq_mask_reg;
    logic heading_reg;
    cvc_pkg::cvc_gate_t gate_reg;

    wire en_rise = i_enable && !enable_prev_reg;
    wire en_fall = !i_enable && enable_prev_reg;
    wire active = (state_reg == cvc_pkg::CVC_RUN) || (state_reg == cvc_pkg::CVC_RAMP);
    wire wdog_expired = active && !i_watchdog_bypass_in &&
                        (wdog_reg >= WDOG_CYCLES - 1);

    // Source order is priority order, lowest index wins
    wire [NF-1:0] src_flag = {wdog_expired, i_fault_sense.over_temp,
                            i_fault_sense.cell_over | i_fault_sense.cell_under,
                            i_fault_sense.oc_secondary, i_fault_sense.oc_primary,
                            i_fault_sense.uvlo_float, i_fault_sense.uvlo_main};
    wire [3*NF-1:0] src_code = {FC_WATCHDOG, FC_OVER_TEMP, FC_CELL, FC_OC_SECONDARY,
                                    FC_OC_PRIMARY, FC_UVLO_FLOAT, FC_UVLO_MAIN};

    logic [2:0] live_code;
    always_comb
    begin
        live_code = cvc_pkg::FAULT_NONE;
        for (int i = NF - 1; i >= 0; i--)
        begin
            if (src_flag[i])
                live_code = src_code[3*i +: 3];
        end
    end

    wire live_fault = (live_code != cvc_pkg::FAULT_NONE);
    // Override keeps reporting but stops the shutdown latch
    wire latch_fault = live_fault && !i_latch_override_in;

    ////////////////////////////////////////////////////////////////////////////
    // Converter state machine
    logic period_end;
    wire [DW-1:0] sp_clip = (i_current_setpoint_voltage > limit_reg) ? limit_reg : i_current_setpoint_voltage;
    wire [DW-1:0] target = (sp_clip > MAX_DUTY) ? MAX_DUTY : sp_clip;

    always_comb
    begin
        state_next = state_reg;
        duty_next = duty_reg;
        case (state_reg)
            cvc_pkg::CVC_IDLE, cvc_pkg::CVC_DONE, cvc_pkg::CVC_FAULT:
            begin
                duty_next = '0;
                if (en_rise)
                    state_next = cvc_pkg::CVC_RUN;
            end
            cvc_pkg::CVC_RUN:
            begin
                // Slew one count per period to limit inrush
                if (period_end && duty_reg < target)
                    duty_next = DW'(duty_reg + 1'b1);
                else if (period_end && duty_reg > target)
                    duty_next = DW'(duty_reg - 1'b1);
                if (en_fall)
                    state_next = cvc_pkg::CVC_RAMP;
            end
            cvc_pkg::CVC_RAMP:
            begin
                if (period_end)
                    duty_next = (duty_reg > STEP) ? DW'(duty_reg - STEP) : '0;
                if (en_rise)
                    state_next = cvc_pkg::CVC_RUN;
                else if (duty_reg == '0)
                    state_next = cvc_pkg::CVC_DONE;
            end
            default:
            begin
                state_next = cvc_pkg::CVC_IDLE;
                duty_next = '0;
            end
        endcase
        if (active && latch_fault)
        begin
            state_next = cvc_pkg::CVC_FAULT;
            duty_next = '0;
        end
    end

    wire enter_done = (state_reg == cvc_pkg::CVC_RAMP) && (state_next == cvc_pkg::CVC_DONE);
    wire enter_fault = active && latch_fault;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= cvc_pkg::CVC_IDLE;
            duty_reg <= '0;
            enable_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            duty_reg <= duty_next;
            enable_prev_reg <= i_enable;
        end
    end

    // Done and fault latches
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            done_reg <= 1'b0;
            fault_reg <= cvc_pkg::FAULT_NONE;
        end
        else
        begin
            if (en_rise)
                done_reg <= 1'b0;
            else if (enter_done)
                done_reg <= 1'b1;
            if (i_latch_override_in)
                fault_reg <= live_code;
            else if (enter_fault)
                fault_reg <= live_code;
            else if (en_rise)
                fault_reg <= cvc_pkg::FAULT_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, restarted by enable rise or a software kick
    logic kick;
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            wdog_reg <= '0;
        else if (!active || en_rise || kick)
            wdog_reg <= '0;
        else if (wdog_reg < WDOG_CYCLES - 1)
            wdog_reg <= wdog_reg + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switching and gate mapping
    logic pwm_on;
    logic pwm_clamp;

    cvc_pwm_gen #(
        .PERIOD(cvc_pkg::PERIOD_CYC),
        .DUTY_W(DW),
        .DEAD(cvc_pkg::DEAD_CYC)
    ) u_pwm (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_duty(duty_reg),
        .o_on(pwm_on),
        .o_clamp(pwm_clamp),
        .o_period_end(period_end)
    );

    // Charge: primary switches, secondaries rectify; discharge: secondary switches
    wire drive_ok = active && !i_test_select_in && !live_fault;
    cvc_pkg::cvc_gate_t gate_w;
    assign gate_w.primary_switch_drive = drive_ok && i_direction && pwm_on;
    assign gate_w.secondary_switch_drive_a = drive_ok && (i_direction ? pwm_clamp : pwm_on);
    assign gate_w.secondary_switch_drive_b = drive_ok && pwm_clamp;
    assign gate_w.clamp = drive_ok && pwm_clamp;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gate_reg <= '0;
            heading_reg <= 1'b1;
        end
        else
        begin
            gate_reg <= gate_w;
            heading_reg <= !i_direction;
        end
    end

    assign o_gate = gate_reg;
    assign o_heading_echo = heading_reg;
    assign o_done = done_reg;
    assign o_fault_code = fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_held_reg;
    logic w_held_reg;
    logic [cvc_pkg::ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign o_s_axi_wready = !w_held_reg && !bvalid_reg;
    assign o_s_axi_arready = !rvalid_reg;
    wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
    wire w_take = i_s_axi_wvalid && o_s_axi_wready;
    wire do_write = aw_held_reg && w_held_reg;
    wire ar_take = i_s_axi_arvalid && o_s_axi_arready;

    wire wr_ctrl = do_write && awaddr_reg == cvc_pkg::REG_CTRL;
    wire wr_stat = do_write && awaddr_reg == cvc_pkg::REG_IRQ_STAT && wstrb_reg[0];
    wire wr_mask = do_write && awaddr_reg == cvc_pkg::REG_IRQ_MASK && wstrb_reg[0];
    wire wr_hit = do_write && (awaddr_reg == cvc_pkg::REG_CTRL || awaddr_reg == cvc_pkg::REG_STATUS ||
                               awaddr_reg == cvc_pkg::REG_IRQ_STAT || awaddr_reg == cvc_pkg::REG_IRQ_MASK);
    assign kick = wr_ctrl && wstrb_reg[cvc_pkg::CTRL_KICK_BIT / 8] && wdata_reg[cvc_pkg::CTRL_KICK_BIT];

    wire [31:0] status_w = (32'(state_reg) << cvc_pkg::STAT_STATE_LSB) |
                           (32'(done_reg) << cvc_pkg::STAT_DONE_BIT) |
                           (32'(i_direction) << cvc_pkg::STAT_DIR_BIT) |
                           (32'(i_enable) << cvc_pkg::STAT_EN_BIT) |
                           (32'(fault_reg) << cvc_pkg::STAT_FAULT_LSB) |
                           (32'(duty_reg) << cvc_pkg::STAT_DUTY_LSB);
    wire rd_hit = i_s_axi_araddr == cvc_pkg::REG_CTRL || i_s_axi_araddr == cvc_pkg::REG_STATUS ||
                  i_s_axi_araddr == cvc_pkg::REG_IRQ_STAT || i_s_axi_araddr == cvc_pkg::REG_IRQ_MASK;
    wire [31:0] rd_mux = (i_s_axi_araddr == cvc_pkg::REG_CTRL) ? (32'(limit_reg) << cvc_pkg::CTRL_LIMIT_LSB) :
                         (i_s_axi_araddr == cvc_pkg::REG_STATUS) ? status_w :
                         (i_s_axi_araddr == cvc_pkg::REG_IRQ_STAT) ? 32'(irq_stat_reg) :
                         (i_s_axi_araddr == cvc_pkg::REG_IRQ_MASK) ? 32'(irq_mask_reg) : 32'h0000_0000;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= cvc_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= i_s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= i_s_axi_wdata;
                wstrb_reg <= i_s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? cvc_pkg::RESP_OKAY : cvc_pkg::RESP_SLVERR;
            end
            else if (bvalid_reg && i_s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= cvc_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? cvc_pkg::RESP_OKAY : cvc_pkg::RESP_SLVERR;
        end
        else if (rvalid_reg && i_s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign o_s_axi_bvalid = bvalid_reg;
    assign o_s_axi_bresp = bresp_reg;
    assign o_s_axi_rvalid = rvalid_reg;
    assign o_s_axi_rdata = rdata_reg;
    assign o_s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Control and interrupt registers
    wire [cvc_pkg::IRQ_W-1:0] irq_event = {enter_fault, enter_done};
    wire [cvc_pkg::IRQ_W-1:0] irq_clear = wr_stat ? wdata_reg[cvc_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            limit_reg <= cvc_pkg::CTRL_LIMIT_RST;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end
        else
        begin
            if (wr_ctrl && wstrb_reg[0] && wstrb_reg[1])
                limit_reg <= wdata_reg[cvc_pkg::CTRL_LIMIT_LSB +: DW];
            if (wr_mask)
                irq_mask_reg <= wdata_reg[cvc_pkg::IRQ_W-1:0];
            // A new event wins over a clear in the same cycle
            irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
        end
    end
    assign o_irq = |(irq_stat_reg & irq_mask_reg);

endmodule : cvc_ctrl

/* File: bench/cvc_ctrl_monitor.sv */
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module cvc_ctrl_monitor (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_direction,
    input wire logic i_latch_override_in,
    input wire logic i_test_select_in,
    input wire logic i_s_axi_bready,
    input wire logic o_heading_echo,
    input wire logic o_done,
    input wire logic [2:0] o_fault_code,
    input wire cvc_pkg::cvc_gate_t o_gate,
    input wire logic o_irq,
    input wire logic o_s_axi_bvalid,
    input wire logic [1:0] o_s_axi_bresp
);
    // 300 us at 5 ns
    localparam int RAMP_MAX = 60000;
    int ramp_cnt;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    // Ramp age, armed only by a real enable fall
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            ramp_cnt <= 0;
        else if (i_enable || o_done || o_fault_code != 3'h0)
            ramp_cnt <= 0;
        else if ($fell(i_enable) || ramp_cnt != 0)
            ramp_cnt <= ramp_cnt + 1;
    end
    ////////////////////////////////////////
    AST_ECHO_INV: assert property (!$past(i_rst) |-> o_heading_echo == !$past(i_direction))
        else $error("echo is not the inverted direction");
    AST_RISE_CLEARS: assert property ($rose(i_enable) && !$past(i_rst) && !i_latch_override_in
        |=> !o_done && o_fault_code == 3'h0) else $error("enable rise left a latch set");
    AST_DONE_LATCH: assert property (o_done && !$rose(i_enable) |=> o_done)
        else $error("done dropped without enable rise");
    AST_FAULT_LATCH: assert property (o_fault_code != 3'h0 && !i_latch_override_in && !$rose(i_enable)
        |=> $stable(o_fault_code)) else $error("fault code changed while latched");
    AST_FAULT_SHUTS: assert property (o_fault_code != 3'h0 && !i_latch_override_in && !$rose(i_enable)
        |=> o_gate == '0) else $error("gates active after fault");
    AST_TEST_GATES: assert property (i_test_select_in [*3] |-> o_gate == '0)
        else $error("gates active in test mode");
    AST_DONE_GATES: assert property (o_done [*2] |-> o_gate == '0)
        else $error("gates active while done");
    AST_DISCHARGE_PRI: assert property (!i_direction [*3] |-> !o_gate.primary_switch_drive)
        else $error("primary drive active in discharge");
    AST_RAMP_BOUND: assert property (ramp_cnt < RAMP_MAX)
        else $error("ramp down took too long");
    AST_BRESP_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response not held");
    cover property ($rose(o_done));
    cover property (o_fault_code == 3'h7);
    cover property ($rose(o_irq));
endmodule : cvc_ctrl_monitor

bind cvc_ctrl cvc_ctrl_monitor u_mon (.*);

/* File: bench/cvc_matrix_model.sv */
// Switch matrix driver model: enable, direction and override straps
`timescale 1ns/1ps
module cvc_matrix_model (
    input wire logic i_clk,
    input wire logic i_cmd_en,
    input wire logic i_cmd_dir,
    input wire logic i_cmd_lor,
    output logic o_enable,
    output logic o_direction,
    output logic o_latch_override_in
);
    initial
    begin
        o_enable = 1'h0;
        o_direction = 1'h0;
        o_latch_override_in = 1'h0;
    end
    // Levels change only just after an edge, like a real driver
    always @(posedge i_clk)
    begin
        o_enable <= i_cmd_en;
        o_direction <= i_cmd_dir;
        o_latch_override_in <= i_cmd_lor;
    end
endmodule : cvc_matrix_model

/* File: bench/cvc_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module cvc_ctrl_tb;
    logic i_core_clk = 1'h0;
    logic i_rst = 1'h1;
    logic i_enable, i_direction, i_latch_override_in, o_heading_echo, o_done, o_irq;
    logic i_test_select_in = 1'h0;
    logic i_watchdog_bypass_in = 1'h1;
    logic [9:0] i_current_setpoint_voltage = 10'h028;
    cvc_pkg::cvc_fault_in_t i_fault_sense = '0;
    logic [2:0] o_fault_code, code;
    cvc_pkg::cvc_gate_t o_gate;
    logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, q;
    logic [3:0] i_s_axi_wstrb = 4'hF, acc;
    logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
    logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
    logic cmd_en = 1'h0, cmd_dir = 1'h0, cmd_lor = 1'h0;
    logic [6:0] sense;
    // Rows are {direction, fault sense, expected code}
    logic [10:0] rows [10] = '{11'h400, 11'h000, 11'h601, 11'h102, 11'h483,
                               11'h044, 11'h425, 11'h015, 11'h40E, 11'h209};
    int num_errors = 0;
    int checks_done = 0;

    always #2.5 i_core_clk = ~i_core_clk;

    cvc_ctrl #(.WDOG_CYCLES(200)) uut (.*);
    cvc_matrix_model u_drv (.i_clk(i_core_clk), .i_cmd_en(cmd_en), .i_cmd_dir(cmd_dir), .i_cmd_lor(cmd_lor),
        .o_enable(i_enable), .o_direction(i_direction), .o_latch_override_in(i_latch_override_in));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : cyc

    // One bus transfer; each channel is released at its own handshake
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'h0;
        dd = !w;
        @(posedge i_core_clk);
        i_s_axi_awaddr <= a;
        i_s_axi_araddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= w;
        i_s_axi_wvalid <= w;
        i_s_axi_arvalid <= !w;
        i_s_axi_rready <= !w;
        while (!(ad && dd))
        begin
            @(posedge i_core_clk);
            ad = ad | (w ? o_s_axi_awready : o_s_axi_arready);
            dd = dd | o_s_axi_wready;
            i_s_axi_awvalid <= w & !ad;
            i_s_axi_arvalid <= !w & !ad;
            i_s_axi_wvalid <= w & !dd;
        end
        while ((w ? o_s_axi_bvalid : o_s_axi_rvalid) !== 1'h1) @(posedge i_core_clk);
        if (w)
        begin
            i_s_axi_bready <= 1'h1;
            @(posedge i_core_clk);
        end
        r = w ? o_s_axi_bresp : o_s_axi_rresp;
        q = o_s_axi_rdata;
        i_s_axi_bready <= 1'h0;
        i_s_axi_rready <= 1'h0;
    endtask : xfer
    ////////////////////////////////////////
    initial
    begin
        cyc(10);
        i_rst <= 1'h0;
        for (int i = 0; i < 10; i++)
        begin
            sense = rows[i][9:3];
            code = rows[i][2:0];
            cmd_dir <= rows[i][10];
            cmd_en <= 1'h1;
            cyc(3);
            chk(o_done, 0);
            chk(o_fault_code, 0);
            chk(o_heading_echo, !cmd_dir);
            acc = 4'h0;
            for (int n = 0; n < 3000; n++) @(posedge i_core_clk) acc = acc | o_gate;
            chk(acc, cmd_dir ? 4'hF : 4'h7);
            if (sense != 7'h00)
            begin
                i_fault_sense <= sense;
                cyc(6);
                chk(o_fault_code, code);
                chk(o_gate, 0);
                i_fault_sense <= '0;
                cmd_en <= 1'h0;
                cyc(2);
            end
            else
            begin
                cmd_en <= 1'h0;
                for (int n = 0; n < 60000 && o_done !== 1'h1; n++) @(posedge i_core_clk);
                cyc(4);
                chk(o_done, 1);
                chk(o_gate, 0);
            end
        end
        // Interrupt mask, sticky clear and unmapped places
        xfer(1'h0, cvc_pkg::REG_IRQ_MASK, 32'h0);
        chk(q, 0);
        chk(o_irq, 0);
        xfer(1'h1, cvc_pkg::REG_IRQ_MASK, 32'h3);
        cyc(2);
        chk(o_irq, 1);
        xfer(1'h1, cvc_pkg::REG_IRQ_STAT, 32'h3);
        cyc(2);
        chk(o_irq, 0);
        xfer(1'h0, cvc_pkg::REG_IRQ_STAT, 32'h0);
        chk(q, 0);
        xfer(1'h0, 8'h10, 32'h0);
        chk(r, cvc_pkg::RESP_SLVERR);
        chk(q, 0);
        xfer(1'h1, 8'h14, 32'hFFFF_FFFF);
        chk(r, cvc_pkg::RESP_SLVERR);
        // Watchdog: a kick postpones expiry, silence ends in a fault
        i_watchdog_bypass_in <= 1'h0;
        cmd_en <= 1'h1;
        cyc(150);
        xfer(1'h1, cvc_pkg::REG_CTRL, 32'h0001_0310);
        cyc(100);
        chk(o_fault_code, 0);
        cyc(200);
        chk(o_fault_code, 3'h7);
        chk(o_irq, 1);
        cmd_en <= 1'h0;
        i_watchdog_bypass_in <= 1'h1;
        cyc(3);
        // Override lets the code follow the live fault
        cmd_lor <= 1'h1;
        cmd_en <= 1'h1;
        cyc(10);
        i_fault_sense <= 7'h01;
        cyc(6);
        chk(o_fault_code, 3'h6);
        i_fault_sense <= '0;
        cyc(6);
        chk(o_fault_code, 0);
        cmd_lor <= 1'h0;
        i_test_select_in <= 1'h1;
        cyc(4);
        chk(o_gate, 0);
        i_test_select_in <= 1'h0;
        cyc(20);
        i_rst <= 1'h1;
        cyc(2);
        chk(o_heading_echo, 1);
        chk(o_done, 0);
        chk(o_fault_code, 0);
        i_rst <= 1'h0;
        cmd_en <= 1'h0;
        cyc(20);
        close_out;
    end

    initial
    begin
        #400us;
        num_errors++;
        close_out;
    end
endmodule : cvc_ctrl_tb
